/* File: src/dpr_ram.sv */
// dual-port 18-bit burst ram with an axi4-lite control and status window
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module dpr_ram #(
  parameter int ADDR_W = 13
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire dpr_pkg::dpr_pin_in_t left_pins,
  input wire dpr_pkg::dpr_pin_in_t right_pins,
  output dpr_pkg::dpr_pin_out_t left_pins_out,
  output dpr_pkg::dpr_pin_out_t right_pins_out,
  input wire logic [dpr_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dpr_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int NP = dpr_pkg::NUM_PORTS;
  localparam int LW = dpr_pkg::LANE_W;

  // 2**12 or 2**13 words of 18 bits; not reset, like any sram
  logic [dpr_pkg::WORD_W-1:0] mem_q [2**ADDR_W];

  dpr_pkg::dpr_pin_in_t pin_in [NP];
  dpr_pkg::dpr_pin_out_t pin_out [NP];
  logic [ADDR_W-1:0] acc_addr [NP];
  logic [1:0] wr_lanes [NP];
  logic [dpr_pkg::WORD_W-1:0] wr_data [NP];
  logic [dpr_pkg::WORD_W-1:0] rd_word [NP];
  logic [ADDR_W-1:0] cnt [NP];
  logic [NP-1:0] powered_down;
  logic [NP-1:0] pipelined;

  logic [1:0] ctrl_ff, nxt_ctrl;

  assign pin_in[0] = left_pins;
  assign pin_in[1] = right_pins;

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      // read sees the array before this edge's writes: whole old word
      assign rd_word[gp] = mem_q[acc_addr[gp]];
      dpr_port #(
        .ADDR_W(ADDR_W)
      ) u_port (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .port_enable(ctrl_ff[gp]),
        .pins(pin_in[gp]),
        .rd_word(rd_word[gp]),
        .acc_addr(acc_addr[gp]),
        .wr_lanes(wr_lanes[gp]),
        .wr_data(wr_data[gp]),
        .cnt(cnt[gp]),
        .powered_down(powered_down[gp]),
        .pipelined(pipelined[gp]),
        .pins_out(pin_out[gp])
      );
    end
  endgenerate

  assign left_pins_out = pin_out[0];
  assign right_pins_out = pin_out[1];

  // the right port is written last, so it wins a same-word collision;
  // controllers must not count on that
  always_ff @(posedge aclk) begin
    for (int p = 0; p < NP; p++) begin
      if (wr_lanes[p][0]) begin
        mem_q[acc_addr[p]][LW-1:0] <= wr_data[p][LW-1:0];
      end
      if (wr_lanes[p][1]) begin
        mem_q[acc_addr[p]][2*LW-1:LW] <= wr_data[p][2*LW-1:LW];
      end
    end
  end

  // ---- axi4-lite slave ----
  logic aw_got_ff, nxt_aw_got;
  logic [dpr_pkg::AXI_ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
  logic w_got_ff, nxt_w_got;
  logic [31:0] w_data_ff, nxt_w_data;
  logic w_strb0_ff, nxt_w_strb0;
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic aw_hs, w_hs, ar_hs, do_wr;
  logic [dpr_pkg::AXI_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_word;
  logic wr_strb0;

  assign aw_hs = s_axi_awvalid & awready_ff;
  assign w_hs = s_axi_wvalid & wready_ff;
  assign ar_hs = s_axi_arvalid & arready_ff;
  assign do_wr = (aw_got_ff | aw_hs) & (w_got_ff | w_hs) & ~bvalid_ff;
  assign wr_addr = aw_got_ff ? aw_addr_ff : s_axi_awaddr;
  assign wr_word = w_got_ff ? w_data_ff : s_axi_wdata;
  assign wr_strb0 = w_got_ff ? w_strb0_ff : s_axi_wstrb[0];

  always_comb begin
    nxt_aw_got = aw_got_ff | aw_hs;
    nxt_aw_addr = aw_hs ? s_axi_awaddr : aw_addr_ff;
    nxt_w_got = w_got_ff | w_hs;
    nxt_w_data = w_hs ? s_axi_wdata : w_data_ff;
    nxt_w_strb0 = w_hs ? s_axi_wstrb[0] : w_strb0_ff;
    nxt_bvalid = bvalid_ff & ~s_axi_bready;
    nxt_bresp = bresp_ff;
    nxt_ctrl = ctrl_ff;
    if (do_wr) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = dpr_pkg::RESP_OKAY;
      if (wr_addr == dpr_pkg::OFS_CTRL) begin
        if (wr_strb0) begin
          nxt_ctrl = wr_word[1:0];
        end
      end else if (wr_addr == dpr_pkg::OFS_STAT_L || wr_addr == dpr_pkg::OFS_STAT_R) begin
        nxt_bresp = dpr_pkg::RESP_OKAY;
      end else begin
        nxt_bresp = dpr_pkg::RESP_SLVERR;
      end
    end
    // one write at a time: no new address or data until the response is taken
    nxt_awready = ~nxt_aw_got & ~nxt_bvalid;
    nxt_wready = ~nxt_w_got & ~nxt_bvalid;
  end

  always_comb begin
    nxt_rvalid = rvalid_ff & ~s_axi_rready;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (ar_hs) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = '0;
      nxt_rresp = dpr_pkg::RESP_OKAY;
      if (s_axi_araddr == dpr_pkg::OFS_CTRL) begin
        nxt_rdata[1:0] = ctrl_ff;
      end else if (s_axi_araddr == dpr_pkg::OFS_STAT_L) begin
        nxt_rdata[ADDR_W-1:0] = cnt[0];
        nxt_rdata[dpr_pkg::STAT_PD_BIT] = powered_down[0];
        nxt_rdata[dpr_pkg::STAT_MODE_BIT] = pipelined[0];
      end else if (s_axi_araddr == dpr_pkg::OFS_STAT_R) begin
        nxt_rdata[ADDR_W-1:0] = cnt[1];
        nxt_rdata[dpr_pkg::STAT_PD_BIT] = powered_down[1];
        nxt_rdata[dpr_pkg::STAT_MODE_BIT] = pipelined[1];
      end else begin
        nxt_rresp = dpr_pkg::RESP_SLVERR;
      end
    end
    nxt_arready = ~nxt_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_got_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb0_ff <= 1'b0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= dpr_pkg::RESP_OKAY;
      ctrl_ff <= dpr_pkg::CTRL_RST;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= dpr_pkg::RESP_OKAY;
    end else if (ce) begin
      aw_got_ff <= nxt_aw_got;
      aw_addr_ff <= nxt_aw_addr;
      w_got_ff <= nxt_w_got;
      w_data_ff <= nxt_w_data;
      w_strb0_ff <= nxt_w_strb0;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      ctrl_ff <= nxt_ctrl;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  AST_WRITE_LANDS: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_lanes[0] == 2'h3 && wr_lanes[1] == dpr_pkg::LANES_OFF
    |=> mem_q[$past(acc_addr[0])] == $past(wr_data[0]))
    else $error("left port write did not land within the cycle");
  AST_DISABLED_PORT: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_ff[1] |-> wr_lanes[1] == dpr_pkg::LANES_OFF)
    else $error("disabled right port wrote the array");
  AST_BRESP_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid_ff && !s_axi_bready |=> bvalid_ff && $stable(bresp_ff))
    else $error("write response dropped before it was taken");
endmodule

/* File: include/dpr_pkg.sv */
// shared constants, register map and pin bundles for the dual-port burst ram
package dpr_pkg;
  localparam int ADDR_W_MAX = 13;
  localparam int WORD_W = 18;
  localparam int LANE_W = 9;
  localparam int NUM_PORTS = 2;
  localparam int AXI_ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT_L = 8'h04;
  localparam logic [7:0] OFS_STAT_R = 8'h08;
  // ctrl: bit p enables port p; both enabled after reset
  localparam logic [1:0] CTRL_RST = 2'h3;
  // status fields: counter in low bits
  localparam int STAT_PD_BIT = 16;
  localparam int STAT_MODE_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] LANES_OFF = 2'h0;

  typedef struct packed {
    logic tick;
    logic address_strobe_n;
    logic count_advance_n;
    logic counter_clear_n;
    logic port_select_low_active;
    logic port_select_high_active;
    logic output_mode_select;
    logic lower_lane_select_n;
    logic upper_lane_select_n;
    logic output_enable_n;
    logic read_write_n;
    logic [ADDR_W_MAX-1:0] address_lines;
    logic [WORD_W-1:0] data_lines_in;
  } dpr_pin_in_t;

  typedef struct packed {
    logic [WORD_W-1:0] data_lines_out;
    logic [1:0] data_lines_oe;
  } dpr_pin_out_t;
endpackage

/* File: src/dpr_port.sv */
// one ram port: captured controls, burst counter and output staging
`timescale 1ns/100ps
module dpr_port #(
  parameter int ADDR_W = 13
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic port_enable,
  input wire dpr_pkg::dpr_pin_in_t pins,
  input wire logic [dpr_pkg::WORD_W-1:0] rd_word,
  output logic [ADDR_W-1:0] acc_addr,
  output logic [1:0] wr_lanes,
  output logic [dpr_pkg::WORD_W-1:0] wr_data,
  output logic [ADDR_W-1:0] cnt,
  output logic powered_down,
  output logic pipelined,
  output dpr_pkg::dpr_pin_out_t pins_out
);
  logic act;
  logic sel;
  logic rd;
  logic [1:0] lanes;
  logic [ADDR_W-1:0] cnt_ff, nxt_cnt;
  logic pd_ff, nxt_pd;
  logic mode_ff, nxt_mode;
  logic [dpr_pkg::WORD_W-1:0] s1_data_ff, nxt_s1_data;
  logic [1:0] s1_en_ff, nxt_s1_en;
  logic [dpr_pkg::WORD_W-1:0] dout_ff, nxt_dout;
  logic [1:0] oe_ff, nxt_oe;
  // a gated port clock is modelled by tick: no tick, no edge for this port
  assign act = ce & pins.tick;
  assign sel = ~pins.port_select_low_active & pins.port_select_high_active & port_enable;
  assign rd = sel & pins.read_write_n;
  assign lanes = {~pins.upper_lane_select_n, ~pins.lower_lane_select_n};

  always_comb begin
    nxt_cnt = cnt_ff;
    if (!pins.counter_clear_n) begin
      nxt_cnt = '0;
    end else if (!pins.address_strobe_n) begin
      nxt_cnt = pins.address_lines[ADDR_W-1:0];
    end else if (!pins.count_advance_n) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  // the array is read and written at the address being captured, so a write
  // lands in the capture cycle itself rather than waiting for the next edge
  assign acc_addr = nxt_cnt;
  assign wr_lanes = (act & sel & ~pins.read_write_n) ? lanes : dpr_pkg::LANES_OFF;
  assign wr_data = pins.data_lines_in;

  always_comb begin
    nxt_pd = ~sel;
    nxt_mode = pins.output_mode_select;
    nxt_s1_data = rd_word;
    nxt_s1_en = (rd & ~pins.output_enable_n) ? lanes : dpr_pkg::LANES_OFF;
    if (pins.output_mode_select) begin
      // stage register holds the previous capture; empty after deselect
      nxt_dout = s1_data_ff;
      nxt_oe = s1_en_ff;
    end else begin
      nxt_dout = rd_word;
      nxt_oe = nxt_s1_en;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
      pd_ff <= 1'b1;
      mode_ff <= 1'b0;
      s1_data_ff <= '0;
      s1_en_ff <= dpr_pkg::LANES_OFF;
      dout_ff <= '0;
      oe_ff <= dpr_pkg::LANES_OFF;
    end else if (act) begin
      cnt_ff <= nxt_cnt;
      pd_ff <= nxt_pd;
      mode_ff <= nxt_mode;
      s1_data_ff <= nxt_s1_data;
      s1_en_ff <= nxt_s1_en;
      dout_ff <= nxt_dout;
      oe_ff <= nxt_oe;
    end
  end

  assign cnt = cnt_ff;
  assign powered_down = pd_ff;
  assign pipelined = mode_ff;
  assign pins_out = {dout_ff, oe_ff};

  sequence seq_desel;
    act && !sel;
  endsequence
  sequence seq_sel_read;
    act && rd && !pins.output_enable_n && pins.output_mode_select;
  endsequence

  AST_CLEAR_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
    act && !pins.counter_clear_n |=> cnt_ff == '0)
    else $error("counter clear did not zero the counter");
  AST_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    act && pins.counter_clear_n && !pins.address_strobe_n
    |=> cnt_ff == $past(pins.address_lines[ADDR_W-1:0]))
    else $error("address strobe did not load the counter");
  AST_ADVANCE: assert property (@(posedge aclk) disable iff (!aresetn)
    act && pins.counter_clear_n && pins.address_strobe_n && !pins.count_advance_n
    |=> cnt_ff == ADDR_W'($past(cnt_ff) + 1'b1))
    else $error("counter did not advance by one");
  AST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (!act || (pins.counter_clear_n && pins.address_strobe_n && pins.count_advance_n))
    |=> $stable(cnt_ff))
    else $error("counter moved without a cause");
  AST_DESEL_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_desel |=> pd_ff && (oe_ff == dpr_pkg::LANES_OFF || $past(pins.output_mode_select)))
    else $error("deselected port drives its data lines");
  AST_PIPE_REACTIVATE: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_desel ##1 seq_sel_read |=> oe_ff == dpr_pkg::LANES_OFF)
    else $error("pipelined outputs resumed without a selected cycle");
  AST_FLOW_DATA: assert property (@(posedge aclk) disable iff (!aresetn)
    act && rd && !pins.output_mode_select |=> dout_ff == $past(rd_word))
    else $error("flow-through data not from the captured address");
endmodule

/* File: bench/dpr_ctl_model.sv */
// controller-side model that drives one ram port's pins
`timescale 1ns/100ps
module dpr_ctl_model (
  input wire logic aclk,
  output dpr_pkg::dpr_pin_in_t pins
);
  // idle: deselected, no strobes, port clock stopped
  initial pins = {1'h0, 3'h7, 2'h2, 1'h0, 2'h3, 2'h3, 13'h0, 18'h0};

  // one port edge carrying p, then idle edges with the port clock gated
  task automatic xfer(input dpr_pkg::dpr_pin_in_t p, input int idle);
    @(posedge aclk);
    pins <= p;
    repeat (idle) begin
      @(posedge aclk);
      pins.tick <= 1'h0;
      // released data lines must not look like the last word
      pins.data_lines_in <= ~p.data_lines_in;
    end
  endtask
endmodule

/* File: bench/tb.sv */
// self-checking bench for the dual-port burst ram
`timescale 1ns/100ps
module tb;
  localparam int AW = 12;
  localparam logic [2:0] LD = 3'h3, ADV = 3'h5, HOLD = 3'h7;
  localparam logic [1:0] SEL = 2'h1;
  typedef struct {int e; logic [1:0] oe; logic [17:0] d;} dpr_exp_t;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, rand_ce = 1'h0;
  dpr_pkg::dpr_pin_in_t pin_in [2];
  dpr_pkg::dpr_pin_out_t pin_out [2];
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, ctrl = 2'h3;
  logic [31:0] seed = 32'h3d12;
  logic [17:0] mem [4096];
  logic [AW-1:0] cnt [2];
  logic pd [2], md [2];
  int ecnt [2] = '{0, 0}, seen [2] = '{0, 0}, cycles = 0, miscompares = 0, compares = 0;
  dpr_exp_t q [2][$];
  dpr_exp_t st [2];
  logic [1:0] bq [$];
  logic [33:0] rq [$];

  always #2.5 aclk = ~aclk;
  always @(posedge aclk) ce <= rand_ce ? (3'(rnd()) != 3'h0) : 1'h1;

  dpr_ctl_model u_lc (.aclk, .pins(pin_in[0]));
  dpr_ctl_model u_rc (.aclk, .pins(pin_in[1]));
  dpr_ram #(.ADDR_W(AW)) dut (.aclk, .aresetn, .ce, .left_pins(pin_in[0]),
    .right_pins(pin_in[1]), .left_pins_out(pin_out[0]), .right_pins_out(pin_out[1]),
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic dpr_pkg::dpr_pin_in_t mk(input logic [2:0] c, input logic [1:0] cs,
      input logic m, input logic [1:0] ln, input logic rw, input logic [11:0] a,
      input logic [17:0] d);
    return {1'h1, c, cs, m, ln, 1'h0, rw, 1'h0, a, d};
  endfunction

  function automatic logic [17:0] lm(input logic [1:0] l);
    return {{9{l[1]}}, {9{l[0]}}};
  endfunction

  function automatic logic [31:0] stat(input int i);
    return {14'h0, md[i], pd[i], 4'h0, cnt[i]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen_v, input logic [31:0] exp_v);
    compares++;
    if (seen_v !== exp_v) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic go(input int i, input dpr_pkg::dpr_pin_in_t p, input int idle);
    if (i == 1) u_rc.xfer(p, idle);
    else u_lc.xfer(p, idle);
  endtask

  // one strobe load then advances, random stalls; ends with the port clock stopped
  task automatic burst(input int i, input logic m, input logic [11:0] base, input logic rw,
      input logic rl);
    for (int k = 0; k < 8; k++)
      go(i, mk(k ? ADV : LD, SEL, m, rl ? 2'(rnd()) : 2'h0, rw, base, 18'(rnd())),
        int'(rnd() % 3) + (k == 7));
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fork
      begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'h0; end
      begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'h0; end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask

  // reference model: reads see the array before this edge's writes
  always @(posedge aclk) begin
    logic [AW-1:0] a [2];
    logic sel [2];
    dpr_pkg::dpr_pin_in_t p;
    dpr_exp_t x;
    dpr_exp_t y;
    if (!aresetn) begin
      cnt = '{12'h0, 12'h0};
      pd = '{1'h1, 1'h1};
      st[0].oe = 2'h0;
      st[1].oe = 2'h0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        p = pin_in[i];
        sel[i] = p.tick && !p.port_select_low_active && p.port_select_high_active && ctrl[i];
        if (p.tick) begin
          ecnt[i]++;
          a[i] = !p.counter_clear_n ? 12'h0 : !p.address_strobe_n ? p.address_lines[AW-1:0] :
            !p.count_advance_n ? cnt[i] + 12'h1 : cnt[i];
          cnt[i] = a[i];
          x.oe = (sel[i] && p.read_write_n && !p.output_enable_n) ?
            ~{p.upper_lane_select_n, p.lower_lane_select_n} : 2'h0;
          x.d = mem[a[i]];
          x.e = ecnt[i];
          // pipelined edges show the stage filled by the previous port edge
          if (p.output_mode_select) begin
            y = st[i];
            st[i] = x;
            x = y;
            x.e = ecnt[i];
          end else begin
            st[i] = x;
          end
          if (x.oe != 2'h0) q[i].push_back(x);
          pd[i] = !sel[i];
          md[i] = p.output_mode_select;
        end
      end
      for (int i = 0; i < 2; i++) begin
        p = pin_in[i];
        if (sel[i] && !p.read_write_n) begin
          if (!p.lower_lane_select_n) mem[a[i]][8:0] = p.data_lines_in[8:0];
          if (!p.upper_lane_select_n) mem[a[i]][17:9] = p.data_lines_in[17:9];
        end
      end
    end
  end

  // port watcher: after each port edge, any drive must match the oldest note
  always @(negedge aclk) begin
    dpr_exp_t x;
    for (int i = 0; i < 2; i++) begin
      if (aresetn && seen[i] != ecnt[i]) begin
        seen[i] = ecnt[i];
        if (pin_out[i].data_lines_oe !== 2'h0 || (q[i].size() > 0 && q[i][0].e == ecnt[i])) begin
          if (q[i].size() == 0) begin
            check("stray drive", 32'(pin_out[i].data_lines_oe), 32'h0);
          end else begin
            x = q[i].pop_front();
            check("read edge", 32'(ecnt[i]), 32'(x.e));
            check("lanes", 32'(pin_out[i].data_lines_oe), 32'(x.oe));
            check("data", 32'(pin_out[i].data_lines_out & lm(x.oe)), 32'(x.d & lm(x.oe)));
          end
        end
      end
    end
  end

  always @(posedge aclk) begin
    logic [33:0] r;
    if (aresetn && s_axi_rvalid && s_axi_rready) begin
      r = rq.pop_front();
      check("rdata", s_axi_rdata, r[31:0]);
      check("rresp", 32'(s_axi_rresp), 32'(r[33:32]));
    end
    if (aresetn && s_axi_bvalid && s_axi_bready)
      check("bresp", 32'(s_axi_bresp), 32'(bq.pop_front()));
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    logic [11:0] b;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(dpr_pkg::OFS_CTRL, 32'h3, dpr_pkg::RESP_OKAY);
    axi_rd(8'h0c, 32'h0, dpr_pkg::RESP_SLVERR);
    axi_wr(8'h40, 32'h0, 4'hf, dpr_pkg::RESP_SLVERR);
    $display("test registers done");
    rand_ce <= 1'h1;
    for (int m = 0; m < 2; m++) begin
      b = m ? 12'hffc : 12'(rnd());
      fork
        begin for (int s = 0; s < 3; s++) burst(0, 1'(m), b, s == 2, s != 0); end
        begin for (int s = 0; s < 3; s++) burst(1, 1'(m), s == 2 ? b : b ^ 12'h800, s == 2,
          s != 0); end
      join
    end
    rand_ce <= 1'h0;
    repeat (2) @(posedge aclk);
    $display("test bursts done");
    go(0, mk(3'h0, SEL, 1'h0, 2'h0, 1'h1, 12'h5, 18'h0), 0);
    go(0, mk(3'h1, SEL, 1'h0, 2'h0, 1'h1, 12'hffe, 18'h0), 0);
    go(0, mk(ADV, SEL, 1'h0, 2'h0, 1'h1, 12'h5, 18'h0), 0);
    go(0, mk(ADV, SEL, 1'h0, 2'h0, 1'h1, 12'h5, 18'h0), 2);
    axi_rd(dpr_pkg::OFS_STAT_L, stat(0), dpr_pkg::RESP_OKAY);
    go(0, mk(LD, SEL, 1'h0, 2'h0, 1'h0, 12'h20, 18'h2a5a5), 0);
    go(0, mk(HOLD, 2'h3, 1'h0, 2'h0, 1'h0, 12'h20, 18'h15a5a), 0);
    go(0, mk(HOLD, 2'h0, 1'h0, 2'h0, 1'h0, 12'h20, 18'h15a5a), 2);
    axi_rd(dpr_pkg::OFS_STAT_L, stat(0), dpr_pkg::RESP_OKAY);
    go(0, mk(HOLD, 2'h0, 1'h1, 2'h0, 1'h1, 12'h20, 18'h0), 0);
    go(0, mk(LD, SEL, 1'h1, 2'h0, 1'h1, 12'h20, 18'h0), 0);
    go(0, mk(LD, SEL, 1'h1, 2'h0, 1'h1, 12'h20, 18'h0), 2);
    axi_rd(dpr_pkg::OFS_STAT_L, stat(0), dpr_pkg::RESP_OKAY);
    $display("test counter and select done");
    axi_wr(dpr_pkg::OFS_CTRL, 32'h2, 4'hf, dpr_pkg::RESP_OKAY);
    ctrl <= 2'h2;
    go(0, mk(LD, SEL, 1'h0, 2'h0, 1'h0, 12'h20, 18'h3ffff), 0);
    go(0, mk(LD, SEL, 1'h0, 2'h0, 1'h1, 12'h20, 18'h0), 2);
    axi_wr(dpr_pkg::OFS_CTRL, 32'h3, 4'h0, dpr_pkg::RESP_OKAY);
    axi_wr(dpr_pkg::OFS_STAT_L, 32'h3, 4'hf, dpr_pkg::RESP_OKAY);
    axi_rd(dpr_pkg::OFS_CTRL, 32'h2, dpr_pkg::RESP_OKAY);
    axi_wr(dpr_pkg::OFS_CTRL, 32'h3, 4'hf, dpr_pkg::RESP_OKAY);
    ctrl <= 2'h3;
    go(0, mk(LD, SEL, 1'h0, 2'h0, 1'h1, 12'h20, 18'h0), 4);
    $display("test port enable done");
    final_report();
  end
endmodule
